// >>> core/pmcsp_map.svh
// Operation
// - Fault-clear command clears every latched fault and releases the alert line.
// - Lock bit 5 set: only lock, page, operation, on/off config writable.
// - Lock bit 6 set: only lock, page and operation writable.
// - A lock bit at zero adds no restriction; other set bits decide.
// - Store-all copies every setting to nonvolatile memory, busy about 50 ms.
// - Restore-all reloads every setting from nonvolatile memory.
// - Store-single copies only the setting whose code is in the data byte.
// - On/off config is fixed: enable follows the on/off pin alone, active high; operation command not consulted.
// - Lock bit 7 at zero leaves write permission to bits 5 and 6.
`ifndef PMCSP_MAP_SVH
`define PMCSP_MAP_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define PMCSP_CMD_PAGE      8'h00
`define PMCSP_CMD_OPERATION 8'h01
`define PMCSP_CMD_ONOFF_CFG 8'h02
`define PMCSP_CMD_FCLR      8'h03
`define PMCSP_CMD_WLOCK     8'h10
`define PMCSP_CMD_STORE_ALL 8'h11
`define PMCSP_CMD_RESTORE   8'h12
`define PMCSP_CMD_STORE_ONE 8'h13
`define PMCSP_CMD_STATUS    8'h78
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PMCSP_DEV_ADDR      7'h40
`define PMCSP_ONOFF_CFG     8'h17
`define PMCSP_OP_RST        8'h80
`define PMCSP_WLOCK_RST     8'h00
`define PMCSP_LOCK_ALL_BIT  7
`define PMCSP_LOCK_MID_BIT  6
`define PMCSP_LOCK_LOW_BIT  5
`define PMCSP_OP_ON_BIT     7
`define PMCSP_CFG_USE_BIT   4
`define PMCSP_CFG_CMD_BIT   3
`define PMCSP_CFG_PIN_BIT   2
`define PMCSP_CFG_POL_BIT   1
// ----------------------------------------
// Timing
// ----------------------------------------
`define PMCSP_CLK_HZ        20000000
`define PMCSP_STORE_MS      50
`define PMCSP_STORE_CYCLES  ((`PMCSP_STORE_MS * `PMCSP_CLK_HZ) / 1000)
`endif

// >>> core/pmcsp_pkg.sv
`default_nettype none
package pmcsp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK_A = 3'b010,
    ST_CMD   = 3'b011,
    ST_ACK_C = 3'b100,
    ST_DATA  = 3'b101,
    ST_ACK_D = 3'b110,
    ST_RD    = 3'b111
  } pmcsp_phase_t;

  typedef struct packed {
    pmcsp_phase_t st;
    logic         ign;
    logic         scl1, scl2, scl3;
    logic         sda1, sda2, sda3;
    logic         pin1, pin2;
    logic [7:0]   sh;
    logic [3:0]   cnt;
    logic         rw;
    logic [7:0]   cmd;
    logic         got_cmd;
    logic         got_data;
    logic [7:0]   data;
    logic         drv;
    logic [7:0]   page;
    logic [7:0]   op;
    logic [7:0]   lock;
    logic [7:0]   fault;
    logic         alert;
    logic [7:0]   nv_op;
    logic [7:0]   nv_lock;
    logic [7:0]   nv_page;
    logic [19:0]  busy_cnt;
    logic         busy;
    logic         out_en;
  } pmcsp_state_t;
endpackage
`default_nettype wire

// >>> core/pmcsp_top.sv
`include "pmcsp_map.svh"
`default_nettype none
module pmcsp_top #(
  parameter logic [19:0] STORE_CYCLES = 20'(`PMCSP_STORE_CYCLES)
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            alert_o,
  output logic            alert_oe_o,
  input  wire logic       onoff_pin_i,
  input  wire logic [7:0] fault_evt_i,
  output logic [7:0]      operation_o,
  output logic            out_en_o,
  output logic            nvm_busy_o
);
  import pmcsp_pkg::*;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic wr_allowed(input logic [7:0] lock, input logic [7:0] code);
    if (lock[`PMCSP_LOCK_ALL_BIT]) begin
      return code == `PMCSP_CMD_WLOCK;
    end else if (lock[`PMCSP_LOCK_MID_BIT]) begin
      return code == `PMCSP_CMD_WLOCK || code == `PMCSP_CMD_PAGE ||
             code == `PMCSP_CMD_OPERATION;
    end else if (lock[`PMCSP_LOCK_LOW_BIT]) begin
      return code == `PMCSP_CMD_WLOCK || code == `PMCSP_CMD_PAGE ||
             code == `PMCSP_CMD_OPERATION || code == `PMCSP_CMD_ONOFF_CFG;
    end else begin
      return 1'b1;
    end
  endfunction

  function automatic logic onoff_eval(input logic [7:0] cfg, input logic op_on,
                                      input logic pin);
    logic pin_ok;
    logic cmd_ok;
    pin_ok = ~cfg[`PMCSP_CFG_PIN_BIT] | (pin == cfg[`PMCSP_CFG_POL_BIT]);
    cmd_ok = ~cfg[`PMCSP_CFG_CMD_BIT] | op_on;
    return ~cfg[`PMCSP_CFG_USE_BIT] | (pin_ok & cmd_ok);
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  pmcsp_state_t r_ff;
  pmcsp_state_t nxt_r;
  logic         scl_rise, scl_fall, bus_start, bus_stop;
  logic         exec_ev, wr_ev, send_ev, wr_ok, fclr_ev;
  logic [7:0]   rd_byte;

  assign scl_rise  = r_ff.scl2 & ~r_ff.scl3;
  assign scl_fall  = ~r_ff.scl2 & r_ff.scl3;
  assign bus_start = r_ff.scl2 & r_ff.scl3 & ~r_ff.sda2 & r_ff.sda3;
  assign bus_stop  = r_ff.scl2 & r_ff.scl3 & r_ff.sda2 & ~r_ff.sda3;
  // Commands act only at stop, so a torn transfer never changes state
  assign exec_ev   = bus_stop & r_ff.got_cmd & ~r_ff.rw;
  assign wr_ev     = exec_ev & r_ff.got_data;
  assign send_ev   = exec_ev & ~r_ff.got_data;
  assign wr_ok     = wr_allowed(r_ff.lock, r_ff.cmd);
  assign fclr_ev   = send_ev & (r_ff.cmd == `PMCSP_CMD_FCLR);

  always_comb begin
    case (r_ff.cmd)
      `PMCSP_CMD_PAGE:      rd_byte = r_ff.page;
      `PMCSP_CMD_OPERATION: rd_byte = r_ff.op;
      `PMCSP_CMD_ONOFF_CFG: rd_byte = `PMCSP_ONOFF_CFG;
      `PMCSP_CMD_WLOCK:     rd_byte = r_ff.lock;
      `PMCSP_CMD_STATUS:    rd_byte = r_ff.fault;
      default:              rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.scl1 = scl_i;
    nxt_r.scl2 = r_ff.scl1;
    nxt_r.scl3 = r_ff.scl2;
    nxt_r.sda1 = sda_i;
    nxt_r.sda2 = r_ff.sda1;
    nxt_r.sda3 = r_ff.sda2;
    nxt_r.pin1 = onoff_pin_i;
    nxt_r.pin2 = r_ff.pin1;
    if (r_ff.busy_cnt != 20'h00000) begin
      nxt_r.busy_cnt = r_ff.busy_cnt - 20'h00001;
    end
    // New fault events win over a clear in the same cycle
    nxt_r.fault = (fclr_ev ? 8'h00 : r_ff.fault) | fault_evt_i;
    if (bus_start) begin
      nxt_r.st       = ST_ADDR;
      nxt_r.ign      = 1'b0;
      nxt_r.cnt      = 4'h0;
      nxt_r.drv      = 1'b0;
      nxt_r.got_data = 1'b0;
    end else if (bus_stop) begin
      nxt_r.st       = ST_IDLE;
      nxt_r.drv      = 1'b0;
      nxt_r.got_cmd  = 1'b0;
      nxt_r.got_data = 1'b0;
      if (wr_ev && wr_ok) begin
        case (r_ff.cmd)
          `PMCSP_CMD_PAGE:      nxt_r.page = r_ff.data;
          `PMCSP_CMD_OPERATION: nxt_r.op = r_ff.data;
          `PMCSP_CMD_WLOCK:     nxt_r.lock = r_ff.data;
          `PMCSP_CMD_STORE_ONE: begin
            if (!r_ff.busy) begin
              nxt_r.busy_cnt = STORE_CYCLES;
              case (r_ff.data)
                `PMCSP_CMD_PAGE:      nxt_r.nv_page = r_ff.page;
                `PMCSP_CMD_OPERATION: nxt_r.nv_op = r_ff.op;
                `PMCSP_CMD_WLOCK:     nxt_r.nv_lock = r_ff.lock;
                default:              nxt_r.busy_cnt = 20'h00000;
              endcase
            end
          end
          default: nxt_r.page = r_ff.page;
        endcase
      end
      if (send_ev && wr_ok && !r_ff.busy) begin
        if (r_ff.cmd == `PMCSP_CMD_STORE_ALL) begin
          nxt_r.nv_op    = r_ff.op;
          nxt_r.nv_lock  = r_ff.lock;
          nxt_r.nv_page  = r_ff.page;
          nxt_r.busy_cnt = STORE_CYCLES;
        end else if (r_ff.cmd == `PMCSP_CMD_RESTORE) begin
          nxt_r.op   = r_ff.nv_op;
          nxt_r.lock = r_ff.nv_lock;
          nxt_r.page = r_ff.nv_page;
        end
      end
    end else if (!r_ff.ign) begin
      case (r_ff.st)
        ST_ADDR, ST_CMD, ST_DATA: begin
          if (scl_rise) begin
            nxt_r.sh  = {r_ff.sh[6:0], r_ff.sda2};
            nxt_r.cnt = r_ff.cnt + 4'h1;
          end else if (scl_fall && r_ff.cnt == 4'h8) begin
            nxt_r.cnt = 4'h0;
            nxt_r.drv = 1'b1;
            if (r_ff.st == ST_ADDR) begin
              nxt_r.rw  = r_ff.sh[0];
              nxt_r.st  = ST_ACK_A;
              // Foreign address: stay off the bus until the next start
              nxt_r.ign = r_ff.sh[7:1] != `PMCSP_DEV_ADDR;
              nxt_r.drv = r_ff.sh[7:1] == `PMCSP_DEV_ADDR;
            end else if (r_ff.st == ST_CMD) begin
              nxt_r.cmd     = r_ff.sh;
              nxt_r.got_cmd = 1'b1;
              nxt_r.st      = ST_ACK_C;
            end else begin
              nxt_r.data     = r_ff.sh;
              nxt_r.got_data = 1'b1;
              nxt_r.st       = ST_ACK_D;
            end
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            if (r_ff.rw) begin
              nxt_r.sh  = rd_byte;
              nxt_r.drv = ~rd_byte[7];
              nxt_r.cnt = 4'h1;
              nxt_r.st  = ST_RD;
            end else begin
              nxt_r.drv = 1'b0;
              nxt_r.st  = ST_CMD;
            end
          end
        end
        ST_ACK_C: begin
          if (scl_fall) begin
            nxt_r.drv = 1'b0;
            nxt_r.st  = ST_DATA;
          end
        end
        ST_ACK_D: begin
          if (scl_fall) begin
            nxt_r.drv = 1'b0;
            nxt_r.ign = 1'b1;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (r_ff.cnt == 4'h8) begin
              nxt_r.drv = 1'b0;
              nxt_r.ign = 1'b1;
            end else begin
              nxt_r.drv = ~r_ff.sh[6];
              nxt_r.sh  = {r_ff.sh[6:0], 1'b0};
              nxt_r.cnt = r_ff.cnt + 4'h1;
            end
          end
        end
        default: nxt_r.drv = 1'b0;
      endcase
    end
    nxt_r.busy   = nxt_r.busy_cnt != 20'h00000;
    nxt_r.alert  = |nxt_r.fault;
    nxt_r.out_en = onoff_eval(`PMCSP_ONOFF_CFG, r_ff.op[`PMCSP_OP_ON_BIT], r_ff.pin2);
  end

  localparam pmcsp_state_t ST_RST = '{
    st: ST_IDLE, scl1: 1'b1, scl2: 1'b1, scl3: 1'b1, sda1: 1'b1, sda2: 1'b1,
    sda3: 1'b1, op: `PMCSP_OP_RST, nv_op: `PMCSP_OP_RST, lock: `PMCSP_WLOCK_RST,
    nv_lock: `PMCSP_WLOCK_RST, default: '0};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= ST_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign sda_o       = 1'b0;
  assign sda_oe_o    = ~r_ff.drv;
  assign alert_o     = 1'b0;
  assign alert_oe_o  = ~r_ff.alert;
  assign operation_o = r_ff.op;
  assign out_en_o    = r_ff.out_en;
  assign nvm_busy_o  = r_ff.busy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  fault_clear_a: assert property (fclr_ev && fault_evt_i == 8'h00 |=>
    r_ff.fault == 8'h00 && alert_oe_o) else $error("fault clear left faults or alert");
  lock_all_a: assert property (wr_ev && r_ff.lock[7] && r_ff.cmd != `PMCSP_CMD_WLOCK
    |=> $stable(r_ff.op) && $stable(r_ff.page)) else $error("write passed full lock");
  lock_mid_a: assert property (wr_ev && r_ff.lock[7:5] == 3'b010 &&
    r_ff.cmd == `PMCSP_CMD_PAGE |=> r_ff.page == $past(r_ff.data))
    else $error("page write refused under middle lock");
  lock_low_a: assert property (wr_ev && r_ff.lock[7:5] == 3'b001 &&
    r_ff.cmd == `PMCSP_CMD_STORE_ONE |=> !$rose(r_ff.busy))
    else $error("store passed low lock");
  lock_free_a: assert property (wr_ev && r_ff.lock[7:5] == 3'b000 &&
    r_ff.cmd == `PMCSP_CMD_OPERATION |=> r_ff.op == $past(r_ff.data))
    else $error("unlocked write lost");
  store_all_a: assert property (send_ev && wr_ok && !r_ff.busy &&
    r_ff.cmd == `PMCSP_CMD_STORE_ALL |=> r_ff.nv_op == $past(r_ff.op) && r_ff.busy[*8])
    else $error("store all did not copy or hold busy");
  restore_a: assert property (send_ev && wr_ok && !r_ff.busy &&
    r_ff.cmd == `PMCSP_CMD_RESTORE |=> r_ff.op == $past(r_ff.nv_op) &&
    r_ff.lock == $past(r_ff.nv_lock)) else $error("restore did not reload");
  store_one_a: assert property (wr_ev && wr_ok && !r_ff.busy &&
    r_ff.cmd == `PMCSP_CMD_STORE_ONE && r_ff.data == `PMCSP_CMD_OPERATION |=>
    r_ff.nv_op == $past(r_ff.op) && $stable(r_ff.nv_lock)) else $error("store one wrong");
  // Fixed config: pin active high, operation bit not consulted
  onoff_a: assert property (out_en_o == $past(r_ff.pin2))
    else $error("output enable mismatch");
endmodule
`default_nettype wire

// >>> test/pmcsp_host.sv
`default_nettype none
module pmcsp_host (
  input  wire logic clk_i,
  input  wire logic dev_oe_i,
  input  wire logic dev_val_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv;
  // Pull-up on the line: a released wire reads high, low wins
  assign sda_o = drv & (dev_oe_i | dev_val_i);
  initial begin
    scl_o = 1'b1;
    drv   = 1'b1;
  end
  // ----------------------------------------
  // One clock phase: 8 clk low, 8 clk high
  // ----------------------------------------
  task automatic phase(input logic a, input logic b, input logic s, output logic r);
    repeat (4) @(posedge clk_i);
    drv <= a;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    drv <= b;
    repeat (4) @(posedge clk_i);
    r = sda_o;
    scl_o <= s;
  endtask
  task automatic bus_start();
    logic r;
    phase(1'b1, 1'b0, 1'b0, r);
  endtask
  task automatic bus_stop();
    logic r;
    phase(1'b0, 1'b1, 1'b1, r);
  endtask
  // Last bit released by host: ack from device, or nack on a read
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      phase(d[i], d[i], 1'b0, r);
      q[i] = r;
    end
    phase(1'b1, 1'b1, 1'b0, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// >>> test/pmbus_config_store_protect_tb.sv
`include "pmcsp_map.svh"
`default_nettype none
module pmbus_config_store_protect_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Short store so the run stays brief
  localparam logic [19:0] STORE_N = 20'h00258;
  localparam logic [7:0]  C_OP    = `PMCSP_CMD_OPERATION;
  localparam logic [7:0]  C_LK    = `PMCSP_CMD_WLOCK;
  logic       clk, resetn, scl, sda, sda_dv, sda_oe, alert_v, alert_oe, pin, out_en, busy;
  logic [7:0] fevt, op;
  int         err_count, checks_done, run_len, last_len;
  pmcsp_top #(.STORE_CYCLES(STORE_N)) u_dut (
    .clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_dv),
    .sda_oe_o(sda_oe), .alert_o(alert_v), .alert_oe_o(alert_oe), .onoff_pin_i(pin),
    .fault_evt_i(fevt), .operation_o(op), .out_en_o(out_en), .nvm_busy_o(busy)
  );
  pmcsp_host u_host (
    .clk_i(clk), .dev_oe_i(sda_oe), .dev_val_i(sda_dv), .scl_o(scl), .sda_o(sda)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    run_len <= busy ? run_len + 1 : 0;
    if (busy) last_len <= run_len + 1;
  end
  // ----------------------------------------
  // Compare, report and bus helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic two);
    logic [7:0] q;
    logic       a;
    u_host.bus_start();
    u_host.xfer({`PMCSP_DEV_ADDR, 1'b0}, q, a);
    chk(32'(a), 32'h1);
    u_host.xfer(c, q, a);
    if (two) u_host.xfer(d, q, a);
    u_host.bus_stop();
    repeat (8) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] q;
    logic       a;
    u_host.bus_start();
    u_host.xfer({`PMCSP_DEV_ADDR, 1'b0}, q, a);
    u_host.xfer(c, q, a);
    u_host.bus_start();
    u_host.xfer({`PMCSP_DEV_ADDR, 1'b1}, q, a);
    u_host.xfer(8'hFF, q, a);
    u_host.bus_stop();
    repeat (8) @(negedge clk);
    chk(32'(q), 32'(exp));
  endtask
  // Host side: no command until the store has run out
  task automatic wait_store();
    int n;
    n = 0;
    chk(32'(busy), 32'h1);
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      err_count++;
      test_done();
    end else begin
      chk(32'(last_len), {12'h000, STORE_N});
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset();
    logic [7:0] q;
    logic       a;
    chk(32'(op), 32'h80);
    chk(32'({busy, alert_oe, sda_oe}), 32'h3);
    chk(32'(out_en), 32'h0);
    u_host.bus_start();
    u_host.xfer({7'h41, 1'b0}, q, a);
    u_host.bus_stop();
    chk(32'(a), 32'h0);
    // Fixed config: pin active high, operation bit not consulted
    @(posedge clk);
    pin <= 1'b1;
    repeat (6) @(negedge clk);
    chk(32'(out_en), 32'h1);
    wr(`PMCSP_CMD_ONOFF_CFG, 8'h00, 1'b1);
    rd(`PMCSP_CMD_ONOFF_CFG, `PMCSP_ONOFF_CFG);
    wr(C_OP, 8'h00, 1'b1);
    chk(32'({op, out_en}), 32'h001);
    @(posedge clk);
    pin <= 1'b0;
    wr(C_OP, 8'h80, 1'b1);
    chk(32'({op, out_en}), 32'h100);
  endtask
  task automatic sc_lock();
    wr(C_LK, 8'h20, 1'b1);
    wr(C_OP, 8'h00, 1'b1);
    chk(32'(op), 32'h00);
    wr(`PMCSP_CMD_STORE_ALL, 8'h00, 1'b0);
    chk(32'(busy), 32'h0);
    wr(`PMCSP_CMD_STORE_ONE, C_OP, 1'b1);
    chk(32'(busy), 32'h0);
    wr(C_LK, 8'h40, 1'b1);
    wr(C_OP, 8'h80, 1'b1);
    chk(32'(op), 32'h80);
    wr(`PMCSP_CMD_PAGE, 8'h01, 1'b1);
    rd(`PMCSP_CMD_PAGE, 8'h01);
    wr(C_LK, 8'h80, 1'b1);
    wr(C_OP, 8'h00, 1'b1);
    chk(32'(op), 32'h80);
    rd(C_LK, 8'h80);
    wr(C_LK, 8'h00, 1'b1);
    wr(C_OP, 8'h00, 1'b1);
    chk(32'(op), 32'h00);
    wr(C_OP, 8'h80, 1'b1);
  endtask
  task automatic sc_fault();
    @(posedge clk);
    fevt <= 8'h05;
    @(posedge clk);
    fevt <= 8'h00;
    repeat (4) @(negedge clk);
    chk(32'({alert_v, alert_oe}), 32'h0);
    rd(`PMCSP_CMD_STATUS, 8'h05);
    wr(`PMCSP_CMD_FCLR, 8'h00, 1'b0);
    chk(32'({alert_v, alert_oe}), 32'h1);
    rd(`PMCSP_CMD_STATUS, 8'h00);
  endtask
  task automatic sc_store();
    wr(`PMCSP_CMD_STORE_ALL, 8'h00, 1'b0);
    chk(32'(busy), 32'h1);
    wait_store();
    wr(C_OP, 8'h00, 1'b1);
    wr(`PMCSP_CMD_RESTORE, 8'h00, 1'b0);
    chk(32'(op), 32'h80);
    wr(C_OP, 8'h00, 1'b1);
    wr(`PMCSP_CMD_STORE_ONE, C_OP, 1'b1);
    wait_store();
    wr(C_OP, 8'h80, 1'b1);
    wr(`PMCSP_CMD_STORE_ONE, `PMCSP_CMD_PAGE, 1'b1);
    wait_store();
    wr(`PMCSP_CMD_RESTORE, 8'h00, 1'b0);
    chk(32'(op), 32'h00);
  endtask
  initial begin
    resetn      = 1'b0;
    pin         = 1'b0;
    fevt        = 8'h00;
    err_count   = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(negedge clk);
    sc_reset();
    sc_lock();
    sc_fault();
    sc_store();
    test_done();
  end
endmodule
`default_nettype wire
